// File: hw/sleep_mode_wake_controller.sv
// Sleep-mode and wake-up controller with protected regulator register
// Function
// - After wake, wait six peripheral cycles; outside idle add oscillator settling, and regulator settling unless power mode is full.
// - Idle keeps main clock running; wake takes only six cycles.
// - Standby or power-down wake adds one oscillator interval, plus the regulator interval unless power mode is full.
// - Power-down keeps only 32k oscillator and RTC when brown-out, watchdog or PERIODIC_INTERRUPT_TIMER use it.
// - Brown-out wait setting holds execution until detector ready, if slower.
// - Debug break wakes from any sleep state to active.
// - Run-time debugging without break leaves sleep behaviour unchanged.
// - Protected write needs unlock key, then write within four instructions.
// - Protected write without valid unlock leaves register unchanged.
// - Regulator register is key protected; sleep control is freely writable.
// - In standby, peripheral, main and logic clocks run only with run-in-standby set.
// - RTC wakes standby with run-in-standby; power-down only PERIODIC_INTERRUPT_TIMER wakes.
// - Pin change wakes stopped-clock modes only on fully asynchronous pins.
// - Two-wire match wakes all modes except power-down with hot leakage reduce.
// - Logic interrupt wakes power-down only on asynchronous lookup path and without hot leakage reduce.
// - Brown-out oscillator runs in sleep only in sampled mode.
// - Sleep mode field: idle 0, standby 1, power-down 2; others reserved.
// - Power mode field: auto 0, full 1; full gives faster start-up.
`timescale 1ns/10ps
module sleep_mode_wake_controller #(
	parameter int SETTLE_W = sleep_ctrl_pkg::SETTLE_CNT_W
) (
	input  wire logic                    clk_sys_in,
	input  wire logic                    rst_in,
	input  wire logic                    reg_wr_in,
	input  wire logic                    reg_addr_in,
	input  wire logic [7:0]              reg_wdata_in,
	input  wire logic                    key_wr_in,
	input  wire logic [7:0]              key_data_in,
	input  wire logic                    insn_retire_in,
	input  wire logic                    sleep_insn_in,
	input  wire logic                    debug_break_in,
	input  wire sleep_ctrl_pkg::wake_src_t wake_src_in,
	input  wire sleep_ctrl_pkg::wake_src_t wake_en_in,
	input  wire logic                    rtc_run_standby_in,
	input  wire logic                    lut_async_in,
	input  wire logic                    periph_run_standby_in,
	input  wire logic                    logic_run_standby_in,
	input  wire logic                    internal_32k_oscillator_needed_in,
	input  wire logic                    brownout_sampled_in,
	input  wire logic                    brownout_wait_in,
	input  wire logic                    brownout_ready_in,
	input  wire logic [SETTLE_W-1:0]     osc_settle_cycles_in,
	input  wire logic [SETTLE_W-1:0]     reg_settle_cycles_in,
	output logic [7:0]                   sleep_control_out,
	output logic [7:0]                   regulator_control_out,
	output logic                         cpu_halt_out,
	output logic                         wake_done_out,
	output sleep_ctrl_pkg::run_en_t      run_en_out
);

	// ----------------------------------------------------------------
	// Checks
	// ----------------------------------------------------------------
	initial begin
		if (SETTLE_W < 4) begin
			$error("SETTLE_W too narrow");
		end
	end

	// ----------------------------------------------------------------
	// State
	// ----------------------------------------------------------------
	typedef struct packed {
		logic [7:0]                 sleep_control;
		logic [7:0]                 regulator_control;
		sleep_ctrl_pkg::sleep_state_t state;
		logic [2:0]                 slept_mode;
		logic [SETTLE_W-1:0]        wake_cnt;
		logic                       need_bod;
		logic [2:0]                 unlock_left;
		logic                       halt;
		logic                       wake_done;
		sleep_ctrl_pkg::run_en_t    run_en;
	} ctrl_t;

	ctrl_t cur;
	ctrl_t next_cur;

	// Pins from other domains; first stage read only by second stage
	logic [1:0] brdy_sync;
	logic [1:0] pina_sync;
	logic [1:0] dbg_sync;

	always_ff @(posedge clk_sys_in) begin
		if (rst_in) begin
			brdy_sync <= 2'h0;
			pina_sync <= 2'h0;
			dbg_sync  <= 2'h0;
		end else begin
			brdy_sync <= {brdy_sync[0], brownout_ready_in};
			pina_sync <= {pina_sync[0], wake_src_in.pin_async};
			dbg_sync  <= {dbg_sync[0], debug_break_in};
		end
	end

	logic [2:0] mode_sel;
	logic       hot_leak;
	logic       full_regulator_power_mode;
	logic       wake_hit;
	logic [SETTLE_W-1:0] extra;
	logic [SETTLE_W:0]   total;
	sleep_ctrl_pkg::wake_src_t src;

	// ----------------------------------------------------------------
	// Wake qualification
	// ----------------------------------------------------------------
	always_comb begin
		mode_sel   = cur.slept_mode;
		hot_leak   = cur.regulator_control[sleep_ctrl_pkg::HOT_LEAK_POS];
		full_regulator_power_mode = cur.regulator_control[sleep_ctrl_pkg::POWER_MODE_HI:
			sleep_ctrl_pkg::POWER_MODE_LO] == sleep_ctrl_pkg::REGULATOR_POWER_MODE_FULL;
		wake_hit   = 1'b0;
		// Raw pin stays out of the wake logic; only its second stage counts
		src           = wake_src_in;
		src.pin_async = pina_sync[1];
		if (mode_sel == sleep_ctrl_pkg::MODE_IDLE) begin
			wake_hit = |(src & wake_en_in);
		end else if (mode_sel == sleep_ctrl_pkg::MODE_STANDBY) begin
			wake_hit = (pina_sync[1] & wake_en_in.pin_async)
				| (wake_src_in.level_monitor & wake_en_in.level_monitor)
				| (wake_src_in.pin_sync & wake_en_in.pin_sync & periph_run_standby_in)
				| (wake_src_in.rtc & wake_en_in.rtc & rtc_run_standby_in)
				| (wake_src_in.periodic_interrupt_timer & wake_en_in.periodic_interrupt_timer)
				| (wake_src_in.two_wire_match & wake_en_in.two_wire_match)
				| (wake_src_in.logic_lut & wake_en_in.logic_lut)
				| (wake_src_in.usart_sof & wake_en_in.usart_sof)
				| (wake_src_in.timer_standby & wake_en_in.timer_standby);
		end else begin
			wake_hit = (pina_sync[1] & wake_en_in.pin_async)
				| (wake_src_in.level_monitor & wake_en_in.level_monitor)
				| (wake_src_in.periodic_interrupt_timer & wake_en_in.periodic_interrupt_timer)
				| (wake_src_in.two_wire_match & wake_en_in.two_wire_match
					& ~hot_leak)
				| (wake_src_in.logic_lut & wake_en_in.logic_lut
					& lut_async_in & ~hot_leak);
		end
		// Full regulator mode keeps regulator up, so no regulator settle
		total = {1'b0, osc_settle_cycles_in}
			+ (full_regulator_power_mode ? {(SETTLE_W+1){1'b0}} : {1'b0, reg_settle_cycles_in});
		extra = total[SETTLE_W] ? {SETTLE_W{1'b1}} : total[SETTLE_W-1:0];
	end

	// ----------------------------------------------------------------
	// Sequencer and registers
	// ----------------------------------------------------------------
	always_comb begin
		next_cur = cur;
		next_cur.wake_done = 1'b0;
		// Unlock window counts retired instructions
		if (cur.unlock_left != 3'h0 && insn_retire_in) begin
			next_cur.unlock_left = cur.unlock_left - 3'h1;
		end
		if (key_wr_in && key_data_in == sleep_ctrl_pkg::IO_REGISTER_KEY) begin
			next_cur.unlock_left = sleep_ctrl_pkg::UNLOCK_WINDOW;
		end
		if (reg_wr_in) begin
			if (reg_addr_in == sleep_ctrl_pkg::SLEEP_CONTROL_OFS) begin
				next_cur.sleep_control = reg_wdata_in & sleep_ctrl_pkg::SLEEP_CONTROL_MASK;
			end else if (cur.unlock_left != 3'h0) begin
				next_cur.regulator_control = reg_wdata_in
					& sleep_ctrl_pkg::REGULATOR_CONTROL_MASK;
				next_cur.unlock_left = 3'h0;
			end
		end
		case (cur.state)
			sleep_ctrl_pkg::ST_ACTIVE: begin
				// Reserved mode codes do not enter sleep
				if (sleep_insn_in && cur.sleep_control[sleep_ctrl_pkg::SLEEP_ENABLE_POS]
					&& cur.sleep_control[sleep_ctrl_pkg::SLEEP_MODE_HI:
					sleep_ctrl_pkg::SLEEP_MODE_LO] <= sleep_ctrl_pkg::MODE_PDOWN) begin
					next_cur.state      = sleep_ctrl_pkg::ST_SLEEP;
					next_cur.slept_mode = cur.sleep_control[sleep_ctrl_pkg::SLEEP_MODE_HI:
						sleep_ctrl_pkg::SLEEP_MODE_LO];
					next_cur.halt       = 1'b1;
				end
			end
			sleep_ctrl_pkg::ST_SLEEP: begin
				if (wake_hit || dbg_sync[1]) begin
					next_cur.state    = sleep_ctrl_pkg::ST_WAKE;
					next_cur.need_bod = brownout_wait_in;
					if (cur.slept_mode == sleep_ctrl_pkg::MODE_IDLE) begin
						next_cur.wake_cnt = SETTLE_W'(sleep_ctrl_pkg::WAKE_BASE_CYCLES) - 1'b1;
					end else begin
						next_cur.wake_cnt = SETTLE_W'(sleep_ctrl_pkg::WAKE_BASE_CYCLES)
							+ extra - 1'b1;
					end
				end
			end
			sleep_ctrl_pkg::ST_WAKE: begin
				if (cur.wake_cnt != '0) begin
					next_cur.wake_cnt = cur.wake_cnt - 1'b1;
				end else if (!cur.need_bod || brdy_sync[1]) begin
					next_cur.state     = sleep_ctrl_pkg::ST_ACTIVE;
					next_cur.halt      = 1'b0;
					next_cur.wake_done = 1'b1;
				end
			end
			default: begin
				next_cur.state = sleep_ctrl_pkg::ST_ACTIVE;
			end
		endcase
		// Clock gating plan for the mode being entered or held
		next_cur.run_en = '1;
		next_cur.run_en.cpu = ~next_cur.halt;
		if (next_cur.state == sleep_ctrl_pkg::ST_SLEEP) begin
			if (next_cur.slept_mode == sleep_ctrl_pkg::MODE_STANDBY) begin
				next_cur.run_en.main_osc     = periph_run_standby_in;
				next_cur.run_en.periph_other = periph_run_standby_in;
				next_cur.run_en.rtc_clk      = rtc_run_standby_in | internal_32k_oscillator_needed_in;
				next_cur.run_en.logic_clk    = logic_run_standby_in;
				next_cur.run_en.timer_d_clk  = 1'b0;
				next_cur.run_en.brownout_osc = brownout_sampled_in;
				next_cur.run_en.regulator_on = full_regulator_power_mode | periph_run_standby_in;
			end else if (next_cur.slept_mode == sleep_ctrl_pkg::MODE_PDOWN) begin
				next_cur.run_en.main_osc     = 1'b0;
				next_cur.run_en.periph_other = 1'b0;
				next_cur.run_en.rtc_clk      = internal_32k_oscillator_needed_in;
				next_cur.run_en.logic_clk    = 1'b0;
				next_cur.run_en.timer_d_clk  = 1'b0;
				next_cur.run_en.brownout_osc = brownout_sampled_in;
				next_cur.run_en.regulator_on = full_regulator_power_mode;
			end else begin
				next_cur.run_en.brownout_osc = brownout_sampled_in;
			end
		end
		// Debug without a break touches nothing here
		if (rst_in) begin
			next_cur = '0;
		end
	end

	always_ff @(posedge clk_sys_in) begin
		if (rst_in) begin
			cur <= '{sleep_control:     sleep_ctrl_pkg::SLEEP_CONTROL_RST,
				regulator_control: sleep_ctrl_pkg::REGULATOR_CONTROL_RST,
				state:             sleep_ctrl_pkg::ST_ACTIVE,
				slept_mode:        3'h0,
				wake_cnt:          '0,
				need_bod:          1'b0,
				unlock_left:       3'h0,
				halt:              1'b0,
				wake_done:         1'b0,
				run_en:            '1};
		end else begin
			cur <= next_cur;
		end
	end

	assign sleep_control_out     = cur.sleep_control;
	assign regulator_control_out = cur.regulator_control;
	assign cpu_halt_out          = cur.halt;
	assign wake_done_out         = cur.wake_done;
	assign run_en_out            = cur.run_en;

	// ----------------------------------------------------------------
	// Assertions
	// ----------------------------------------------------------------
	a_locked_write_kept: assert property (@(posedge clk_sys_in) disable iff (rst_in)
		reg_wr_in && reg_addr_in == sleep_ctrl_pkg::REGULATOR_CONTROL_OFS
		&& cur.unlock_left == 3'h0 |=> $stable(cur.regulator_control))
		else $error("regulator written while locked");

	a_ctrl_free_write: assert property (@(posedge clk_sys_in) disable iff (rst_in)
		reg_wr_in && reg_addr_in == sleep_ctrl_pkg::SLEEP_CONTROL_OFS
		|=> cur.sleep_control == ($past(reg_wdata_in) & 8'h0F))
		else $error("sleep control write lost");

	a_unlock_window: assert property (@(posedge clk_sys_in) disable iff (rst_in)
		key_wr_in && key_data_in == sleep_ctrl_pkg::IO_REGISTER_KEY
		|=> cur.unlock_left == 3'h4)
		else $error("unlock window not opened");

	a_idle_wake_six: assert property (@(posedge clk_sys_in) disable iff (rst_in)
		cur.state == sleep_ctrl_pkg::ST_SLEEP && cur.slept_mode == 3'h0
		&& wake_hit && !brownout_wait_in
		|=> cur.halt [*6] ##1 !cur.halt)
		else $error("idle wake not six cycles");

	a_debug_break_wakes: assert property (@(posedge clk_sys_in) disable iff (rst_in)
		cur.state == sleep_ctrl_pkg::ST_SLEEP && dbg_sync[1]
		|=> cur.state == sleep_ctrl_pkg::ST_WAKE)
		else $error("debug break ignored");

	a_bod_hold: assert property (@(posedge clk_sys_in) disable iff (rst_in)
		cur.state == sleep_ctrl_pkg::ST_WAKE && cur.need_bod && !brdy_sync[1]
		|=> cur.halt)
		else $error("resumed before brownout ready");

	a_pdown_no_osc: assert property (@(posedge clk_sys_in) disable iff (rst_in)
		cur.state == sleep_ctrl_pkg::ST_SLEEP && cur.slept_mode == 3'h2
		|-> !cur.run_en.main_osc && !cur.run_en.timer_d_clk)
		else $error("clock left on in power-down");

	a_hot_twi_blocked: assert property (@(posedge clk_sys_in) disable iff (rst_in)
		cur.state == sleep_ctrl_pkg::ST_SLEEP && cur.slept_mode == 3'h2
		&& cur.regulator_control[4] && !dbg_sync[1]
		&& wake_src_in.two_wire_match && !pina_sync[1] && !wake_src_in.level_monitor
		&& !wake_src_in.periodic_interrupt_timer
		|=> cur.state == sleep_ctrl_pkg::ST_SLEEP)
		else $error("two-wire woke hot power-down");

	a_reserved_no_sleep: assert property (@(posedge clk_sys_in) disable iff (rst_in)
		cur.state == sleep_ctrl_pkg::ST_ACTIVE && cur.sleep_control[3:1] > 3'h2
		|=> cur.state == sleep_ctrl_pkg::ST_ACTIVE)
		else $error("reserved mode entered sleep");

	a_sleep_taken: assert property (@(posedge clk_sys_in) disable iff (rst_in)
		cur.state == sleep_ctrl_pkg::ST_ACTIVE && sleep_insn_in && cur.sleep_control[0]
		&& cur.sleep_control[3:1] <= 3'h2
		|=> cur.state == sleep_ctrl_pkg::ST_SLEEP && cur.halt)
		else $error("sleep instruction not taken");

	a_no_enable_awake: assert property (@(posedge clk_sys_in) disable iff (rst_in)
		cur.state == sleep_ctrl_pkg::ST_ACTIVE && !cur.sleep_control[0]
		|=> cur.state == sleep_ctrl_pkg::ST_ACTIVE)
		else $error("slept without enable");

	a_break_active_idle: assert property (@(posedge clk_sys_in) disable iff (rst_in)
		cur.state == sleep_ctrl_pkg::ST_ACTIVE && !sleep_insn_in
		|=> cur.state == sleep_ctrl_pkg::ST_ACTIVE && !cur.halt)
		else $error("left active without sleep");

	a_wake_pulse_once: assert property (@(posedge clk_sys_in) disable iff (rst_in)
		cur.wake_done
		|-> !cur.halt ##1 !cur.wake_done)
		else $error("wake pulse malformed");

	a_standby_gating: assert property (@(posedge clk_sys_in) disable iff (rst_in)
		cur.state == sleep_ctrl_pkg::ST_SLEEP && cur.slept_mode == 3'h1
		|-> cur.run_en.periph_other == $past(periph_run_standby_in)
		&& cur.run_en.logic_clk == $past(logic_run_standby_in)
		&& !cur.run_en.timer_d_clk)
		else $error("standby gating wrong");

	a_pdown_rtc_only: assert property (@(posedge clk_sys_in) disable iff (rst_in)
		cur.state == sleep_ctrl_pkg::ST_SLEEP && cur.slept_mode == 3'h2
		|-> cur.run_en.rtc_clk == $past(internal_32k_oscillator_needed_in)
		&& !cur.run_en.logic_clk && !cur.run_en.periph_other)
		else $error("power-down clock plan wrong");

	a_bod_osc_sleep: assert property (@(posedge clk_sys_in) disable iff (rst_in)
		cur.state == sleep_ctrl_pkg::ST_SLEEP
		|-> cur.run_en.brownout_osc == $past(brownout_sampled_in))
		else $error("brownout oscillator plan wrong");

	a_halt_not_active: assert property (@(posedge clk_sys_in) disable iff (rst_in)
		cur.state != sleep_ctrl_pkg::ST_ACTIVE
		|-> cur.halt && !cur.run_en.cpu)
		else $error("core clock on while not active");
endmodule

// File: hw/sleep_ctrl_pkg.sv
// Package: register map, field layout, states and timing of the sleep controller
package sleep_ctrl_pkg;

	// ----------------------------------------------------------------
	// Register map
	// ----------------------------------------------------------------
	localparam logic [0:0] SLEEP_CONTROL_OFS     = 1'h0;
	localparam logic [0:0] REGULATOR_CONTROL_OFS = 1'h1;
	localparam logic [7:0] SLEEP_CONTROL_RST     = 8'h00;
	localparam logic [7:0] REGULATOR_CONTROL_RST = 8'h00;

	// ----------------------------------------------------------------
	// Field positions
	// ----------------------------------------------------------------
	localparam int SLEEP_ENABLE_POS  = 0;
	localparam int SLEEP_MODE_LO     = 1;
	localparam int SLEEP_MODE_HI     = 3;
	localparam int POWER_MODE_LO     = 0;
	localparam int POWER_MODE_HI     = 2;
	localparam int HOT_LEAK_POS      = 4;
	localparam logic [7:0] SLEEP_CONTROL_MASK     = 8'h0F;
	localparam logic [7:0] REGULATOR_CONTROL_MASK = 8'h17;

	// ----------------------------------------------------------------
	// Codes
	// ----------------------------------------------------------------
	localparam logic [2:0] MODE_IDLE     = 3'h0;
	localparam logic [2:0] MODE_STANDBY  = 3'h1;
	localparam logic [2:0] MODE_PDOWN    = 3'h2;
	localparam logic [2:0] REGULATOR_POWER_MODE_AUTO    = 3'h0;
	localparam logic [2:0] REGULATOR_POWER_MODE_FULL    = 3'h1;
	localparam logic [7:0] IO_REGISTER_KEY = 8'hD8;

	// ----------------------------------------------------------------
	// Timing
	// ----------------------------------------------------------------
	localparam logic [3:0] WAKE_BASE_CYCLES  = 4'h6;
	localparam logic [2:0] UNLOCK_WINDOW     = 3'h4;
	localparam int         SETTLE_CNT_W      = 16;

	typedef enum logic [1:0] {
		ST_ACTIVE = 2'b00,
		ST_SLEEP  = 2'b01,
		ST_WAKE   = 2'b11
	} sleep_state_t;

	// Wake source request lines, level
	typedef struct packed {
		logic pin_async;
		logic pin_sync;
		logic level_monitor;
		logic rtc;
		logic periodic_interrupt_timer;
		logic two_wire_match;
		logic logic_lut;
		logic usart_sof;
		logic timer_standby;
		logic other;
	} wake_src_t;

	// Clock run enables during sleep
	typedef struct packed {
		logic cpu;
		logic main_osc;
		logic rtc_clk;
		logic brownout_osc;
		logic logic_clk;
		logic timer_d_clk;
		logic periph_other;
		logic regulator_on;
	} run_en_t;
endpackage

// File: test/cpu_core_model.sv
// Behavioural CPU core model driving register, key, retire and sleep strobes
`timescale 1ns/10ps
module cpu_core_model (
	input  wire logic       clk_sys_in,
	output logic            reg_wr_out,
	output logic            reg_addr_out,
	output logic [7:0]      reg_wdata_out,
	output logic            key_wr_out,
	output logic [7:0]      key_data_out,
	output logic            insn_retire_out,
	output logic            sleep_insn_out
);
	initial begin
		reg_wr_out = 1'b0;
		reg_addr_out = 1'b0;
		reg_wdata_out = 8'h00;
		key_wr_out = 1'b0;
		key_data_out = 8'h00;
		insn_retire_out = 1'b0;
		sleep_insn_out = 1'b0;
	end
	// ----------------------------------------------------------------
	// Bus cycles, each entered just after a rising edge
	// ----------------------------------------------------------------
	task automatic cycle();
		@(posedge clk_sys_in);
		#1;
	endtask
	task automatic reg_write(input logic addr, input logic [7:0] data);
		reg_wr_out = 1'b1;
		reg_addr_out = addr;
		reg_wdata_out = data;
		cycle();
		reg_wr_out = 1'b0;
		// Idle bus shows garbage, never the last value
		reg_wdata_out = ~data;
		// One idle edge, so a following write sees the strobe low first
		cycle();
	endtask
	task automatic key_write(input logic [7:0] key);
		key_wr_out = 1'b1;
		key_data_out = key;
		cycle();
		key_wr_out = 1'b0;
		key_data_out = ~key;
	endtask
	task automatic retire(input int n);
		repeat (n) begin
			insn_retire_out = 1'b1;
			cycle();
			insn_retire_out = 1'b0;
			cycle();
		end
	endtask
	task automatic sleep_op();
		sleep_insn_out = 1'b1;
		cycle();
		sleep_insn_out = 1'b0;
	endtask
endmodule

// File: test/sleep_mode_wake_controller_tb_top.sv
// Self-checking testbench for the sleep-mode and wake-up controller
`timescale 1ns/10ps
module sleep_mode_wake_controller_tb_top;
	logic                      clk_sys_in = 1'b0;
	logic                      rst_in = 1'b1;
	logic                      reg_wr, reg_addr, key_wr, insn_retire, sleep_insn;
	logic [7:0]                reg_wdata, key_data, sleep_control, regulator_control;
	logic                      debug_break = 1'b0;
	sleep_ctrl_pkg::wake_src_t wake_src = '0;
	sleep_ctrl_pkg::wake_src_t wake_en = '1;
	logic                      rtc_rs = 1'b1, lut_async = 1'b0, periph_rs = 1'b0;
	logic                      logic_rs = 1'b0, internal_32k_oscillator = 1'b1, bo_sampled = 1'b1;
	logic                      bo_wait = 1'b0, bo_ready = 1'b1, cpu_halt, wake_done;
	logic [15:0]               osc_settle = 16'h0003, reg_settle = 16'h0002;
	sleep_ctrl_pkg::run_en_t   run_en;
	int                        miscompares = 0, n_tests = 0;
	always #4 clk_sys_in = ~clk_sys_in;
	cpu_core_model cpu (.clk_sys_in(clk_sys_in), .reg_wr_out(reg_wr), .reg_addr_out(reg_addr),
		.reg_wdata_out(reg_wdata), .key_wr_out(key_wr), .key_data_out(key_data),
		.insn_retire_out(insn_retire), .sleep_insn_out(sleep_insn));
	sleep_mode_wake_controller #(.SETTLE_W(16)) uut (.clk_sys_in(clk_sys_in), .rst_in(rst_in),
		.reg_wr_in(reg_wr), .reg_addr_in(reg_addr), .reg_wdata_in(reg_wdata), .key_wr_in(key_wr),
		.key_data_in(key_data), .insn_retire_in(insn_retire), .sleep_insn_in(sleep_insn),
		.debug_break_in(debug_break), .wake_src_in(wake_src), .wake_en_in(wake_en),
		.rtc_run_standby_in(rtc_rs), .lut_async_in(lut_async), .periph_run_standby_in(periph_rs),
		.logic_run_standby_in(logic_rs), .internal_32k_oscillator_needed_in(internal_32k_oscillator),
		.brownout_sampled_in(bo_sampled), .brownout_wait_in(bo_wait),
		.brownout_ready_in(bo_ready), .osc_settle_cycles_in(osc_settle),
		.reg_settle_cycles_in(reg_settle), .sleep_control_out(sleep_control),
		.regulator_control_out(regulator_control), .cpu_halt_out(cpu_halt),
		.wake_done_out(wake_done), .run_en_out(run_en));
	// ----------------------------------------------------------------
	// Shared helpers
	// ----------------------------------------------------------------
	task automatic check(input string what, input logic [7:0] exp, input logic [7:0] got);
		n_tests++;
		if (got !== exp) begin
			miscompares++;
			$display("unexpected %s: expected %h seen %h", what, exp, got);
		end
	endtask
	task automatic unlock_write(input logic [7:0] data);
		cpu.key_write(sleep_ctrl_pkg::IO_REGISTER_KEY);
		cpu.reg_write(1'b1, data);
	endtask
	task automatic sleep_in(input logic [2:0] mode);
		cpu.reg_write(1'b0, {4'h0, mode, 1'b1});
		cpu.sleep_op();
		check("cpu_halt_out", 8'h01, 8'(cpu_halt));
	endtask
	task automatic expect_asleep(input int cycles);
		repeat (cycles) begin
			cpu.cycle();
			check("cpu_halt_out", 8'h01, 8'(cpu_halt));
		end
	endtask
	// Halt must fall inside lo..hi cycles, with wake_done seen on the way
	task automatic wait_wake(input int lo, input int hi);
		int n;
		logic seen;
		n = 0;
		seen = 1'b0;
		while (cpu_halt === 1'b1 && n < 300) begin
			cpu.cycle();
			n++;
			if (wake_done === 1'b1) seen = 1'b1;
		end
		check("wake delay in range", 8'h01, 8'(n >= lo && n <= hi));
		if (n < lo || n > hi) $display("wake delay seen %0d cycles", n);
		check("wake_done_out", 8'h01, 8'(seen));
	endtask
	// ----------------------------------------------------------------
	// Scenarios
	// ----------------------------------------------------------------
	task automatic t_regs();
		check("sleep_control_out", sleep_ctrl_pkg::SLEEP_CONTROL_RST, sleep_control);
		check("run_en_out", 8'hFF, run_en);
		check("regulator_control_out", sleep_ctrl_pkg::REGULATOR_CONTROL_RST, regulator_control);
		check("cpu_halt_out", 8'h00, 8'(cpu_halt));
		cpu.reg_write(1'b0, 8'hFF);
		check("sleep_control_out", 8'h0F, sleep_control);
		cpu.reg_write(1'b1, 8'h11);
		check("regulator_control_out", 8'h00, regulator_control);
		cpu.key_write(8'h5A);
		cpu.reg_write(1'b1, 8'h11);
		check("regulator_control_out", 8'h00, regulator_control);
		cpu.key_write(sleep_ctrl_pkg::IO_REGISTER_KEY);
		cpu.retire(4);
		cpu.reg_write(1'b1, 8'h11);
		check("regulator_control_out", 8'h00, regulator_control);
		cpu.key_write(sleep_ctrl_pkg::IO_REGISTER_KEY);
		cpu.retire(3);
		cpu.reg_write(1'b1, 8'hFF);
		check("regulator_control_out", 8'h17, regulator_control);
		cpu.reg_write(1'b1, 8'h00);
		check("regulator_control_out", 8'h17, regulator_control);
		unlock_write(8'h00);
		cpu.reg_write(1'b0, 8'h07);
		cpu.sleep_op();
		check("cpu_halt_out", 8'h00, 8'(cpu_halt));
		cpu.reg_write(1'b0, 8'h04);
		cpu.sleep_op();
		check("cpu_halt_out", 8'h00, 8'(cpu_halt));
		$display("test registers done");
	endtask
	task automatic t_idle();
		wake_en.other = 1'b0;
		sleep_in(sleep_ctrl_pkg::MODE_IDLE);
		check("main_osc", 8'h01, 8'(run_en.main_osc));
		wake_src.other = 1'b1;
		expect_asleep(10);
		wake_en.other = 1'b1;
		wait_wake(6, 8);
		wake_src.other = 1'b0;
		sleep_in(sleep_ctrl_pkg::MODE_IDLE);
		debug_break = 1'b1;
		wait_wake(6, 10);
		debug_break = 1'b0;
		bo_wait = 1'b1;
		sleep_in(sleep_ctrl_pkg::MODE_IDLE);
		wake_src.rtc = 1'b1;
		wait_wake(6, 8);
		bo_ready = 1'b0;
		sleep_in(sleep_ctrl_pkg::MODE_IDLE);
		expect_asleep(20);
		bo_ready = 1'b1;
		wait_wake(1, 5);
		wake_src.rtc = 1'b0;
		bo_wait = 1'b0;
		$display("test idle done");
	endtask
	task automatic t_standby();
		sleep_in(sleep_ctrl_pkg::MODE_STANDBY);
		check("periph_other", 8'h00, 8'(run_en.periph_other));
		check("logic_clk", 8'h00, 8'(run_en.logic_clk));
		check("timer_d_clk", 8'h00, 8'(run_en.timer_d_clk));
		wake_src.other = 1'b1;
		expect_asleep(12);
		wake_src.rtc = 1'b1;
		wait_wake(11, 13);
		wake_src = '0;
		periph_rs = 1'b1;
		logic_rs = 1'b1;
		unlock_write(8'h01);
		sleep_in(sleep_ctrl_pkg::MODE_STANDBY);
		check("periph_other", 8'h01, 8'(run_en.periph_other));
		check("logic_clk", 8'h01, 8'(run_en.logic_clk));
		wake_src.two_wire_match = 1'b1;
		wait_wake(9, 11);
		wake_src = '0;
		$display("test standby done");
	endtask
	task automatic t_pdown();
		lut_async = 1'b1;
		unlock_write(8'h10);
		sleep_in(sleep_ctrl_pkg::MODE_PDOWN);
		check("main_osc", 8'h00, 8'(run_en.main_osc));
		check("periph_other", 8'h00, 8'(run_en.periph_other));
		check("rtc_clk", 8'h01, 8'(run_en.rtc_clk));
		check("brownout_osc", 8'h01, 8'(run_en.brownout_osc));
		wake_src = 10'h3FF;
		wake_src.pin_async = 1'b0;
		wake_src.periodic_interrupt_timer = 1'b0;
		wake_src.level_monitor = 1'b0;
		expect_asleep(12);
		wake_src.pin_async = 1'b1;
		wait_wake(11, 14);
		wake_src = '0;
		unlock_write(8'h00);
		bo_sampled = 1'b0;
		lut_async = 1'b1;
		sleep_in(sleep_ctrl_pkg::MODE_PDOWN);
		check("brownout_osc", 8'h00, 8'(run_en.brownout_osc));
		wake_src.logic_lut = 1'b1;
		wait_wake(11, 13);
		wake_src = '0;
		$display("test power-down done");
	endtask
	task automatic stop_test();
		$display("comparisons %0d, mismatches %0d", n_tests, miscompares);
		if (miscompares == 0 && n_tests > 0) $display("All checks passed");
		else $display("Checks failed");
		$finish;
	endtask
	initial begin
		repeat (5) @(posedge clk_sys_in);
		#1;
		rst_in = 1'b0;
		t_regs();
		t_idle();
		t_standby();
		t_pdown();
		stop_test();
	end
	initial begin
		// Scenarios take about two hundred cycles
		#100000;
		miscompares++;
		stop_test();
	end
endmodule
